/* design/wdr_watchdog.sv */
// How it works
// - Count ticks at clock/2 when prescale_select is 0, clock/128 when 1.
// - Overflow sets watchdog_reset_flag; hardware reset or service clears it.
// - Software reset sets software_reset_flag; end-of-init clears it.
// - Reset input sets the short hardware flag, and the long one for long, power-on or promoted resets; end-of-init clears both.
// - Power-on flag set from reset input only with power-on detection.
// - Several flags may be set together; end-of-init clears all but the watchdog flag.
// - After software, hardware or watchdog reset: enabled, count from zero, clock/2.
// - Disable honoured only before the first end-of-init or service.
// - Counting continues during idle mode unless disabled.
// - Overflow past FFFF triggers internal reset and drives reset-out low.
// - Watchdog reset waits for a bus cycle that may finish, else aborts it.
// - Hardware reset into bootstrap loading leaves the watchdog disabled.
// - Service clears low byte, loads high byte from reload field, clears flag.
// - Malformed service enters the protection fault trap instead.
// - Flags per reset source follow the fixed source-to-flag table.
// - Bidirectional reset with input still low promotes the reset to long.
// - Timeout equals 2^16 minus reload times 256 prescaled ticks.
`timescale 1ns/1ps
module wdr_watchdog
    import wdr_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_reset_n,
    input  wire wdr_hw_reset_type     i_hw_reset,
    input  wire logic                 i_bidir_enable,
    input  wire logic                 i_reset_pin_n,
    input  wire logic                 i_idle,
    input  wire logic                 i_bus_busy,
    input  wire logic                 i_bus_may_finish,
    input  wire logic [31:0]          i_awaddr,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    output logic [1:0]                o_bresp,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    input  wire logic [31:0]          i_araddr,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp,
    output logic                      o_rvalid,
    input  wire logic                 i_rready,
    output logic                      o_reset_out_n,
    output logic                      o_internal_reset,
    output logic                      o_bus_abort,
    output logic                      o_protection_trap,
    output logic                      o_irq
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] pin_sync_q;
    logic       pin_low;

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            pin_sync_q <= 2'b11;
        else
            pin_sync_q <= {pin_sync_q[0], i_reset_pin_n};
    end
    assign pin_low = !pin_sync_q[1];

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    wdr_bus_state_type bus_q;
    logic [31:0]       awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              aw_have_q, w_have_q;
    logic              wr_fire, rd_fire;
    logic [15:0]       control_q;
    logic [15:0]       count_q;
    logic [WDR_IRQ_BITS-1:0] stat_q;
    logic [WDR_IRQ_BITS-1:0] en_q;

    function automatic logic hit(input logic [31:0] a, input logic [15:0] r);
        hit = (a[31:18] == 14'h0) && (a[17:2] == r);
    endfunction

    assign o_awready = (bus_q == WDR_ST_IDLE) && !aw_have_q;
    assign o_wready  = (bus_q == WDR_ST_IDLE) && !w_have_q;
    assign o_arready = (bus_q == WDR_ST_IDLE) && !aw_have_q && !w_have_q && !i_awvalid && !i_wvalid;
    assign o_bvalid  = (bus_q == WDR_ST_WRESP);
    assign o_rvalid  = (bus_q == WDR_ST_RRESP);
    assign wr_fire   = (bus_q == WDR_ST_IDLE) && aw_have_q && w_have_q;
    assign rd_fire   = i_arvalid && o_arready;

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            bus_q     <= WDR_ST_IDLE;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 32'h0000_0000;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            o_bresp   <= 2'b00;
            o_rresp   <= 2'b00;
            o_rdata   <= 32'h0000_0000;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                awaddr_q  <= i_awaddr;
                aw_have_q <= 1'b1;
            end
            if (i_wvalid && o_wready)
            begin
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
                w_have_q <= 1'b1;
            end
            unique case (bus_q)
                WDR_ST_IDLE:
                begin
                    if (wr_fire)
                    begin
                        aw_have_q <= 1'b0;
                        w_have_q  <= 1'b0;
                        bus_q     <= WDR_ST_WRESP;
                        o_bresp   <= (hit(awaddr_q, WDR_CONTROL_ADDR) || hit(awaddr_q, WDR_COUNT_ADDR)
                                      || hit(awaddr_q, WDR_INT_EN_ADDR) || hit(awaddr_q, WDR_INT_CLR_ADDR)
                                      || hit(awaddr_q, WDR_CMD_ADDR) || hit(awaddr_q, WDR_INT_STAT_ADDR))
                                     ? 2'b00 : 2'b10;
                    end
                    else if (rd_fire)
                    begin
                        bus_q   <= WDR_ST_RRESP;
                        o_rresp <= 2'b00;
                        if (hit(i_araddr, WDR_CONTROL_ADDR))
                            o_rdata <= {16'h0000, control_q};
                        else if (hit(i_araddr, WDR_COUNT_ADDR))
                            o_rdata <= {16'h0000, count_q};
                        else if (hit(i_araddr, WDR_INT_STAT_ADDR))
                            o_rdata <= {30'h0, stat_q};
                        else if (hit(i_araddr, WDR_INT_EN_ADDR))
                            o_rdata <= {30'h0, en_q};
                        else if (hit(i_araddr, WDR_INT_CLR_ADDR) || hit(i_araddr, WDR_CMD_ADDR))
                            o_rdata <= 32'h0000_0000;
                        else
                        begin
                            o_rdata <= 32'h0000_0000;
                            o_rresp <= 2'b10;
                        end
                    end
                end
                WDR_ST_WRESP:
                    if (i_bready)
                        bus_q <= WDR_ST_IDLE;
                WDR_ST_RRESP:
                    if (i_rready)
                        bus_q <= WDR_ST_IDLE;
            endcase
        end
    end

    // Write decode; register data uses the low half-word lanes, commands need all four lanes with the key in the high half-word
    logic wr_ctrl, wr_cmd, wr_en, wr_clr, key_ok;
    logic do_service, do_disable, do_end_of_init_instruction, do_swreset, bad_service;

    assign wr_ctrl     = wr_fire && hit(awaddr_q, WDR_CONTROL_ADDR);
    assign wr_cmd      = wr_fire && hit(awaddr_q, WDR_CMD_ADDR) && (wstrb_q == 4'hf);
    assign wr_en       = wr_fire && hit(awaddr_q, WDR_INT_EN_ADDR) && wstrb_q[0];
    assign wr_clr      = wr_fire && hit(awaddr_q, WDR_INT_CLR_ADDR) && wstrb_q[0];
    assign key_ok      = (wdata_q[31:16] == WDR_CMD_KEY);
    assign do_service  = wr_cmd && key_ok && wdata_q[WDR_CMD_SERVICE];
    assign bad_service = wr_cmd && !key_ok && wdata_q[WDR_CMD_SERVICE];
    assign do_disable  = wr_cmd && key_ok && wdata_q[WDR_CMD_DISABLE];
    assign do_end_of_init_instruction    = wr_cmd && key_ok && wdata_q[WDR_CMD_END_OF_INIT_INSTRUCTION];
    assign do_swreset  = wr_cmd && key_ok && wdata_q[WDR_CMD_SWRESET];

    // ------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------
    logic [6:0] div_q;
    logic       tick, enabled_q, init_open_q, overflow, wd_pending_q, wd_reset, hw_any;

    assign hw_any = i_hw_reset.long_rst || i_hw_reset.short_rst || i_hw_reset.power_on;
    assign tick   = (div_q == (control_q[WDR_PRESCALE_BIT] ? WDR_DIV_SLOW_LAST : WDR_DIV_FAST_LAST));
    assign overflow = enabled_q && tick && (count_q == 16'hffff) && !do_service;

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n || tick || do_service)
            div_q <= 7'h00;
        else
            div_q <= div_q + 7'h01;
    end

    // Count runs regardless of idle: idle only stops the processor
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n || hw_any || do_swreset || wd_reset)
            count_q <= WDR_COUNT_RESET;
        else if (do_service)
            count_q <= {control_q[15:WDR_RELOAD_LSB], 8'h00};
        else if (enabled_q && tick)
            count_q <= count_q + 16'h0001;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            enabled_q   <= 1'b1;
            init_open_q <= 1'b1;
        end
        else if (hw_any || do_swreset || wd_reset)
        begin
            enabled_q   <= !(hw_any && i_hw_reset.bootstrap);
            init_open_q <= 1'b1;
        end
        else
        begin
            if (do_disable && init_open_q)
                enabled_q <= 1'b0;
            if (do_end_of_init_instruction || do_service)
                init_open_q <= 1'b0;
        end
    end

    // Overflow holds off the internal reset while a finishable bus cycle runs
    assign wd_reset    = (overflow || wd_pending_q) && !(i_bus_busy && i_bus_may_finish);
    assign o_bus_abort = wd_reset && i_bus_busy;

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n || wd_reset)
            wd_pending_q <= 1'b0;
        else if (overflow)
            wd_pending_q <= 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            o_internal_reset  <= 1'b0;
            o_reset_out_n     <= 1'b1;
            o_protection_trap <= 1'b0;
        end
        else
        begin
            o_internal_reset  <= wd_reset || do_swreset;
            o_reset_out_n     <= !wd_reset;
            o_protection_trap <= bad_service;
        end
    end

    // ------------------------------------------------------------------
    // Control register and reset flags
    // ------------------------------------------------------------------
    logic promote;
    assign promote = i_bidir_enable && pin_low;

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            control_q <= {WDR_RELOAD_RESET, 8'h00};
        else
        begin
            if (wr_ctrl && wstrb_q[1])
                control_q[15:8] <= wdata_q[15:8];
            // Flags are writable too; set events below win over the write
            if (wr_ctrl && wstrb_q[0])
                control_q[5:0] <= wdata_q[5:0];
            if (do_end_of_init_instruction)
                control_q[5:2] <= 4'h0;
            if (do_service)
                control_q[WDR_WDOG_FLAG_BIT] <= 1'b0;
            if (hw_any || do_swreset || wd_reset)
                control_q[WDR_PRESCALE_BIT] <= 1'b0;
            if (hw_any)
            begin
                control_q[WDR_WDOG_FLAG_BIT] <= 1'b0;
                control_q[WDR_SW_FLAG_BIT]   <= 1'b1;
                control_q[WDR_SHORT_BIT]     <= 1'b1;
                if (i_hw_reset.long_rst || i_hw_reset.power_on || promote)
                    control_q[WDR_LONG_BIT] <= 1'b1;
                if (i_hw_reset.power_on)
                    control_q[WDR_PON_BIT] <= 1'b1;
            end
            if (do_swreset || wd_reset)
            begin
                control_q[WDR_SW_FLAG_BIT] <= 1'b1;
                if (promote)
                begin
                    control_q[WDR_SHORT_BIT] <= 1'b1;
                    control_q[WDR_LONG_BIT]  <= 1'b1;
                end
            end
            if (wd_reset)
                control_q[WDR_WDOG_FLAG_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            en_q <= '0;
        else if (wr_en)
            en_q <= wdata_q[WDR_IRQ_BITS-1:0];
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            stat_q <= '0;
        else
        begin
            for (int k = 0; k < WDR_IRQ_BITS; k++)
                if (wr_clr && wdata_q[k])
                    stat_q[k] <= 1'b0;
            if (overflow)
                stat_q[WDR_IRQ_OVERFLOW] <= 1'b1;
            if (bad_service)
                stat_q[WDR_IRQ_FAULT] <= 1'b1;
        end
    end
    assign o_irq = |(stat_q & en_q);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    service_reload_a: assert property (do_service && !hw_any && !do_swreset && !wd_reset
        |=> count_q == ($past(control_q) & 16'hff00)) else $error("service reload wrong");
    service_flag_a: assert property (do_service && !wd_reset |=> !control_q[WDR_WDOG_FLAG_BIT])
        else $error("service kept flag");
    wd_reset_out_a: assert property (wd_reset |=> !o_reset_out_n && control_q[WDR_WDOG_FLAG_BIT])
        else $error("watchdog reset effects missing");
    end_of_init_instruction_clear_a: assert property (do_end_of_init_instruction && !hw_any && !do_swreset && !wd_reset
        |=> control_q[5:2] == 4'h0) else $error("end_of_init_instruction left flags");
    disable_late_a: assert property (do_disable && !init_open_q && enabled_q && !hw_any
        |=> enabled_q) else $error("late disable honoured");
    restart_zero_a: assert property (do_swreset && !hw_any
        |=> count_q == 16'h0000 && enabled_q && !control_q[WDR_PRESCALE_BIT]) else $error("restart wrong");
    fast_tick_a: assert property (!control_q[WDR_PRESCALE_BIT] && tick && !do_service
        && !$past(control_q[WDR_PRESCALE_BIT]) |-> $past(tick, 2) || !$past(i_reset_n, 2) || $past(do_service, 2))
        else $error("fast prescale not two");
    trap_a: assert property (bad_service && !hw_any && !wd_reset |=> o_protection_trap
        && (count_q == $past(count_q) || count_q == $past(count_q) + 16'h0001)) else $error("bad service not trapped");
    boot_off_a: assert property (hw_any && i_hw_reset.bootstrap |=> !enabled_q)
        else $error("bootstrap left watchdog on");
    idle_count_a: assert property (i_idle && enabled_q && tick && !do_service && !hw_any
        && !do_swreset && !wd_reset |=> count_q == $past(count_q) + 16'h0001) else $error("idle stopped count");

endmodule

/* pkg/wdr_pkg.sv */
package wdr_pkg;

    // ------------------------------------------------------------------
    // Register indices; the AXI4-Lite byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [15:0] WDR_CONTROL_ADDR   = 16'hffae;
    localparam logic [15:0] WDR_COUNT_ADDR     = 16'hffb0;
    localparam logic [15:0] WDR_INT_STAT_ADDR  = 16'hffb4;
    localparam logic [15:0] WDR_INT_EN_ADDR    = 16'hffb8;
    localparam logic [15:0] WDR_INT_CLR_ADDR   = 16'hffbc;
    localparam logic [15:0] WDR_CMD_ADDR       = 16'hffc0;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int WDR_PRESCALE_BIT  = 0;
    localparam int WDR_WDOG_FLAG_BIT = 1;
    localparam int WDR_SW_FLAG_BIT   = 2;
    localparam int WDR_SHORT_BIT     = 3;
    localparam int WDR_LONG_BIT      = 4;
    localparam int WDR_PON_BIT       = 5;
    localparam int WDR_RELOAD_LSB    = 8;

    localparam logic [7:0]  WDR_RELOAD_RESET = 8'h00;
    localparam logic [15:0] WDR_COUNT_RESET  = 16'h0000;

    // Prescale divide counts
    localparam int WDR_DIV_SLOW = 128;
    localparam int WDR_DIV_FAST = 2;
    localparam logic [6:0] WDR_DIV_SLOW_LAST = 7'(WDR_DIV_SLOW - 1);
    localparam logic [6:0] WDR_DIV_FAST_LAST = 7'(WDR_DIV_FAST - 1);

    // Interrupt status bit positions
    localparam int WDR_IRQ_OVERFLOW = 0;
    localparam int WDR_IRQ_FAULT    = 1;
    localparam int WDR_IRQ_BITS     = 2;

    // Command register bits (stand-in for the protected instructions)
    localparam int WDR_CMD_SERVICE = 0;
    localparam int WDR_CMD_DISABLE = 1;
    localparam int WDR_CMD_END_OF_INIT_INSTRUCTION   = 2;
    localparam int WDR_CMD_SWRESET = 3;
    localparam logic [15:0] WDR_CMD_KEY = 16'ha55a;

    typedef struct packed {
        logic long_rst;
        logic short_rst;
        logic power_on;
        logic bootstrap;
    } wdr_hw_reset_type;

    typedef enum logic [2:0] {
        WDR_ST_IDLE  = 3'b001,
        WDR_ST_WRESP = 3'b010,
        WDR_ST_RRESP = 3'b100
    } wdr_bus_state_type;

endpackage

/* tb/wdr_watchdog_tb_top.sv */
`timescale 1ns/1ps
module wdr_watchdog_tb_top;
    import wdr_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------------
    logic             i_clk = 0;
    logic             i_reset_n = 0;
    wdr_hw_reset_type hw = '0;
    logic             bidir = 0, pin_n = 1, idle = 0, busy = 0, may_fin = 0;
    logic [31:0]      awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic             awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic             awready, wready, bvalid, arready, rvalid, rst_out_n, int_rst, abort, trap, irq;
    logic [1:0]       bresp, rresp, r, bw;
    logic [31:0]      d;
    logic [15:0]      dc;
    logic             abort_seen = 0, trap_seen = 0, int_seen = 0;
    int               errors = 0, checks = 0, cyc = 0, t0;
    localparam logic [15:0] CT = WDR_CONTROL_ADDR, CN = WDR_COUNT_ADDR, ST = WDR_INT_STAT_ADDR;
    always #12.5 i_clk = ~i_clk;
    wdr_watchdog dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_hw_reset(hw), .i_bidir_enable(bidir),
        .i_reset_pin_n(pin_n), .i_idle(idle), .i_bus_busy(busy), .i_bus_may_finish(may_fin),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
        .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready), .o_reset_out_n(rst_out_n), .o_internal_reset(int_rst),
        .o_bus_abort(abort), .o_protection_trap(trap), .o_irq(irq));
    // Pulse outputs last one cycle, so they are latched here for later checks
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (abort === 1'b1) abort_seen <= 1'b1;
        if (trap === 1'b1) trap_seen <= 1'b1;
        if (int_rst === 1'b1) int_seen <= 1'b1;
        if (cyc == 60000)
        begin
            errors = errors + 1;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ------------------------------------------------------------------
    // AXI4-Lite master
    // ------------------------------------------------------------------
    task automatic axw(input logic [15:0] a, input logic [31:0] v);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge i_clk);
        awaddr <= {14'h0, a, 2'b00};
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge i_clk);
            aw_ok = aw_ok | (awready === 1'b1);
            w_ok = w_ok | (wready === 1'b1);
            if (aw_ok) awvalid <= 0;
            if (w_ok) wvalid <= 0;
        end
        while (bvalid !== 1'b1) @(posedge i_clk);
        bw = bresp;
        bready <= 0;
    endtask
    task automatic axr(input logic [15:0] a);
        @(posedge i_clk);
        araddr <= {14'h0, a, 2'b00};
        arvalid <= 1;
        rready <= 1;
        do @(posedge i_clk); while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1) @(posedge i_clk);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    task automatic cmd(input int b);
        axw(WDR_CMD_ADDR, {WDR_CMD_KEY, 16'(1 << b)});
    endtask
    // Count advance over a fixed gap of about 204 clocks
    task automatic rate();
        logic [15:0] a;
        axr(CN);
        a = d[15:0];
        repeat (200) @(posedge i_clk);
        axr(CN);
        dc = d[15:0] - a;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_basic();
        axr(CT);
        cmp(d & 32'hffff, 32'h0);
        cmp(irq, 0);
        cmp(int_seen, 0);
        axw(16'h1000, 32'h0);
        cmp(bw, 2'b10);
        axr(16'h1000);
        cmp(r, 2'b10);
        cmp(d, 0);
        rate();
        cmp(dc >= 100 && dc <= 106, 1);
    endtask
    task automatic t_disable();
        cmd(WDR_CMD_DISABLE);
        rate();
        cmp(dc, 0);
        axr(CN);
        dc = d[15:0];
        axw(CN, 32'h1234);
        cmp(bw, 2'b00);
        axr(CN);
        cmp(d[15:0], dc);
    endtask
    task automatic t_sw();
        cmd(WDR_CMD_SWRESET);
        axr(CT);
        cmp(d[7:0], 8'h04);
        cmp(int_seen, 1);
        rate();
        cmp(dc >= 100 && dc <= 106, 1);
        cmd(WDR_CMD_END_OF_INIT_INSTRUCTION);
        axr(CT);
        cmp(d[7:0], 8'h00);
        cmd(WDR_CMD_DISABLE);
        rate();
        cmp(dc >= 100 && dc <= 106, 1);
    endtask
    task automatic t_ovf(input logic pre, input int lo, input int hi);
        axw(CT, {16'h0, 8'hff, 7'h0, pre});
        cmd(WDR_CMD_SERVICE);
        axr(CN);
        cmp(d[15:8], 8'hff);
        t0 = cyc;
        while (rst_out_n !== 1'b0) @(posedge i_clk);
        cmp(cyc - t0 >= lo && cyc - t0 <= hi, 1);
        axr(CT);
        cmp(d[2:0], 3'b110);
    endtask
    task automatic t_irq();
        axr(ST);
        cmp(d[0], 1);
        cmp(irq, 0);
        axw(WDR_INT_EN_ADDR, 32'h1);
        repeat (2) @(posedge i_clk);
        cmp(irq, 1);
        axw(WDR_INT_CLR_ADDR, 32'h1);
        repeat (2) @(posedge i_clk);
        cmp(irq, 0);
        axw(CT, 32'hff02);
        cmd(WDR_CMD_SERVICE);
        axr(CT);
        cmp(d[1], 0);
    endtask
    // Overflow during a bus cycle that may finish waits for that cycle to end
    task automatic t_defer();
        busy <= 1;
        may_fin <= 1;
        axw(CT, 32'hff00);
        cmd(WDR_CMD_SERVICE);
        repeat (530) @(posedge i_clk);
        cmp(irq, 1);
        axr(CT);
        cmp(d[1], 0);
        busy <= 0;
        may_fin <= 0;
        while (rst_out_n !== 1'b0) @(posedge i_clk);
        axr(CT);
        cmp(d[1], 1);
    endtask
    task automatic t_trap();
        axw(WDR_CMD_ADDR, 32'h1234_0001);
        repeat (2) @(posedge i_clk);
        cmp(trap_seen, 1);
        axr(ST);
        cmp(d[1], 1);
    endtask
    // Sources: power-on, long, short, short promoted by a held pin
    task automatic t_hw();
        logic [3:0] src [4] = '{4'b0010, 4'b1000, 4'b0100, 4'b0100};
        logic [7:0] exp [4] = '{8'h3c, 8'h1c, 8'h0c, 8'h1c};
        for (int i = 0; i < 4; i++)
        begin
            bidir <= (i == 3);
            pin_n <= (i != 3);
            repeat (4) @(posedge i_clk);
            hw <= src[i];
            @(posedge i_clk);
            hw <= '0;
            repeat (4) @(posedge i_clk);
            axr(CT);
            cmp(d[7:0], exp[i]);
            cmd(WDR_CMD_END_OF_INIT_INSTRUCTION);
            axr(CT);
            cmp(d[7:0], 8'h00);
        end
        bidir <= 0;
        pin_n <= 1;
        hw <= 4'b0101;
        @(posedge i_clk);
        hw <= '0;
        rate();
        cmp(dc, 0);
    endtask
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1;
        t_basic();
        t_disable();
        t_sw();
        busy <= 1;
        t_ovf(1'b0, 500, 515);
        cmp(abort_seen, 1);
        busy <= 0;
        t_irq();
        t_defer();
        idle <= 1;
        t_ovf(1'b1, 32630, 32790);
        idle <= 0;
        t_trap();
        t_hw();
        stop_test();
    end
endmodule
